// >>> clock_standby_consts.svh
`ifndef CLOCK_STANDBY_CONSTS_SVH
`define CLOCK_STANDBY_CONSTS_SVH

// register byte addresses
`define OFS_SYSCTRL1       4'h0
`define OFS_SYSCTRL2       4'h4
`define OFS_TIMEBASE       4'h8
`define OFS_STATUS         4'hC

// first system control register fields
`define SC1_DEEP_HALT      7
`define SC1_OUT_HIZ        6
`define SC1_WAKE_EDGE      5
`define SC1_WARM_SEL_LO    0
`define SC1_RESET          8'h00

// second system control register fields
`define SC2_HF_ENABLE      7
`define SC2_LF_ENABLE      6
`define SC2_SYSCLK_SEL     5
`define SC2_LIGHT_SLEEP    4
`define SC2_RESET_DUAL     8'hC0
`define SC2_RESET_SINGLE   8'h80

// time base control register fields
`define TB_STAGE7_SEL      4
`define TB_RESET           8'h00

// timing
`define PRESCALE_DIV       2'h3
`define DIVIDER_STAGES     21
`define HF_TO_STAGE7       6
`define WARM_STAGE_HF      16
`define WARM_STAGE_LF      10
`define RESET_OUT_STAGE    12
`define STATES_PER_CYCLE   4

`endif

// >>> clock_standby_pkg.sv
package clock_standby_pkg;

  typedef enum logic [2:0] {
    MODE_SINGLE_RUN,
    MODE_SINGLE_DOZE,
    MODE_OSC_OFF_HOLD,
    MODE_DUAL_FAST_RUN,
    MODE_DUAL_FAST_DOZE,
    MODE_LOW_RATE_RUN,
    MODE_LOW_RATE_DOZE,
    MODE_WARM_UP
  } opMode_t;

  typedef struct packed {
    logic       adr2;
    logic [1:0] adr;
    logic       cyc;
    logic       stb;
    logic       we;
    logic       sel;
    logic [7:0] dat;
  } wbReq_t;

  typedef struct packed {
    logic [3:0] timerClk;
    logic [1:0] serialClk;
    logic       timeBaseClk;
    logic       watchdogClk;
  } periphClk_t;

endpackage : clock_standby_pkg

// >>> system_clock_standby_controller.sv
// The Wishbone register port and the register offsets were decided locally.
`include "clock_standby_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module system_clock_standby_controller (
  input  wire logic                          clk_sys,
  input  wire logic                          reset,
  input  wire logic                          clkEn,
  input  wire logic                          highFreqTick,
  input  wire logic                          lowFreqTick,
  input  wire logic                          dualClockOption,
  input  wire logic                          wakePin,
  input  wire logic                          intRequest,
  input  wire logic                          interruptMasterEnable,
  input  wire logic                          wb_cyc_i,
  input  wire logic                          wb_stb_i,
  input  wire logic                          wb_we_i,
  input  wire logic [3:0]                    wb_adr_i,
  input  wire logic [3:0]                    wb_sel_i,
  input  wire logic [31:0]                   wb_dat_i,
  output logic      [31:0]                   wb_dat_o,
  output logic                               wb_ack_o,
  output logic                               mainClkTick,
  output logic      [1:0]                    machineState,
  output logic                               cpuRun,
  output logic                               watchdogRun,
  output logic                               periphRun,
  output logic                               serviceInterrupt,
  output logic                               highOscOn,
  output logic                               lowOscOn,
  output logic                               lowOscPinsAsPorts,
  output logic                               outputsHiZ,
  output logic                               dividerPulseOut,
  output clock_standby_pkg::periphClk_t      periphClk,
  output logic                               resetOutRelease
);
  import clock_standby_pkg::*;

  logic [7:0]  sysCtrl1_ff;
  logic [7:0]  sysCtrl2_ff;
  logic [7:0]  timeBase_ff;
  logic        dualMode_ff;
  logic        modeCaptured_ff;
  opMode_t     mode_ff;
  opMode_t     resumeMode_ff;
  logic        useLowClk_ff;
  logic [1:0]  prescale_ff;
  logic [20:0] divider_ff;
  logic [20:0] dividerPrev_ff;
  logic [1:0]  state_ff;
  logic        wakePrev_ff;
  logic        warmStart_ff;
  logic        warmArmed_ff;

  logic        busHit;
  logic        hfTick;
  logic        stage7In;
  logic        lowDirect;
  logic        mainTick;
  logic        cycleEnd;
  logic        wakeEvent;
  logic        warmBit;
  logic [20:0] nxt_divider;
  logic [20:0] stageRise;
  logic        wrStrobe;

  // read mux, used for the read data only
  function automatic logic [7:0] regRead(input logic [3:0] adr,
                                         input logic [7:0] r1, input logic [7:0] r2,
                                         input logic [7:0] tb, input logic [7:0] st);
    case (adr)
      `OFS_SYSCTRL1: regRead = r1;
      `OFS_SYSCTRL2: regRead = r2;
      `OFS_TIMEBASE: regRead = tb;
      `OFS_STATUS:   regRead = st;
      default:       regRead = 8'h00;
    endcase
  endfunction : regRead

  function automatic logic isFastMode(input opMode_t m);
    isFastMode = (m == MODE_DUAL_FAST_RUN) || (m == MODE_DUAL_FAST_DOZE);
  endfunction : isFastMode

  // mode groups: run for the outputs, doze for register self-clear
  function automatic logic isRunMode(input opMode_t m);
    isRunMode = (m == MODE_SINGLE_RUN) || (m == MODE_DUAL_FAST_RUN) ||
                (m == MODE_LOW_RATE_RUN);
  endfunction : isRunMode

  function automatic logic isDozeMode(input opMode_t m);
    isDozeMode = (m == MODE_SINGLE_DOZE) || (m == MODE_DUAL_FAST_DOZE) ||
                 (m == MODE_LOW_RATE_DOZE);
  endfunction : isDozeMode

  assign busHit = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign hfTick = highFreqTick && highOscOn;
  assign wrStrobe = busHit && wb_we_i && wb_sel_i[0];

  // prescaler runs off HF and is never cleared
  always_ff @(posedge clk_sys) begin
    if (clkEn && hfTick && !lowDirect) begin
      case (prescale_ff)
        2'h0:    prescale_ff <= 2'h1;
        2'h1:    prescale_ff <= 2'h2;
        2'h2:    prescale_ff <= 2'h3;
        default: prescale_ff <= 2'h0;
      endcase
    end
  end

  // stage seven source
  always_comb begin
    if (!dualMode_ff) begin
      stage7In = hfTick && (prescale_ff == `PRESCALE_DIV) &&
                 (&divider_ff[`HF_TO_STAGE7-1:0]);
    end else if (useLowClk_ff) begin
      stage7In = lowFreqTick;
    end else if (timeBase_ff[`TB_STAGE7_SEL]) begin
      stage7In = lowFreqTick;
    end else begin
      stage7In = hfTick && (prescale_ff == `PRESCALE_DIV) &&
                 (&divider_ff[`HF_TO_STAGE7-1:0]);
    end
  end

  assign lowDirect = dualMode_ff && useLowClk_ff;

  always_comb begin
    nxt_divider = divider_ff;
    if (!lowDirect && hfTick && prescale_ff == `PRESCALE_DIV) begin
      nxt_divider[5:0] = divider_ff[5:0] + 6'h01;
    end
    if (stage7In) begin
      nxt_divider[20:6] = divider_ff[20:6] + 15'h0001;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      divider_ff     <= 21'h00_0000;
      dividerPrev_ff <= 21'h00_0000;
    end else if (clkEn) begin
      if (warmStart_ff) begin
        divider_ff <= 21'h00_0000;
      end else if (mode_ff != MODE_OSC_OFF_HOLD) begin
        divider_ff <= nxt_divider;
      end
      dividerPrev_ff <= divider_ff;
    end
  end

  // rising edge of every divider stage
  for (genvar g = 0; g < `DIVIDER_STAGES; g++) begin : gen_stageRise
    assign stageRise[g] = divider_ff[g] && !dividerPrev_ff[g];
  end

  // main system clock: HF/1 or LF
  assign mainTick = (mode_ff == MODE_OSC_OFF_HOLD || mode_ff == MODE_WARM_UP) ? 1'b0 :
                    (useLowClk_ff ? lowFreqTick : hfTick);
  assign cycleEnd = mainTick && (state_ff == 2'h3);

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_ff <= 2'h0;
    end else if (clkEn && mainTick) begin
      state_ff <= state_ff + 2'h1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      useLowClk_ff <= 1'b0;
    end else if (clkEn && cycleEnd) begin
      useLowClk_ff <= dualMode_ff && sysCtrl2_ff[`SC2_SYSCLK_SEL];
    end
  end

  // reset option is latched after release
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      modeCaptured_ff <= 1'b0;
      dualMode_ff     <= 1'b0;
    end else if (clkEn && !modeCaptured_ff) begin
      modeCaptured_ff <= 1'b1;
      dualMode_ff     <= dualClockOption;
    end
  end

  assign wakeEvent = sysCtrl1_ff[`SC1_WAKE_EDGE] ? (wakePin && !wakePrev_ff) : wakePin;
  // warm-up ends on the next rise of the chosen stage
  assign warmBit   = stageRise[useLowClk_ff ? `WARM_STAGE_LF : `WARM_STAGE_HF];

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wakePrev_ff <= 1'b0;
    end else if (clkEn) begin
      wakePrev_ff <= wakePin;
    end
  end

  // stand-by sequencer
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      mode_ff          <= MODE_SINGLE_RUN;
      resumeMode_ff    <= MODE_SINGLE_RUN;
      warmStart_ff     <= 1'b0;
      warmArmed_ff     <= 1'b0;
      serviceInterrupt <= 1'b0;
    end else if (clkEn) begin
      warmStart_ff     <= 1'b0;
      serviceInterrupt <= 1'b0;
      case (mode_ff)
        MODE_SINGLE_RUN, MODE_DUAL_FAST_RUN, MODE_LOW_RATE_RUN: begin
          if (!modeCaptured_ff) begin
            mode_ff <= dualClockOption ? MODE_DUAL_FAST_RUN : MODE_SINGLE_RUN;
          end else if (sysCtrl1_ff[`SC1_DEEP_HALT]) begin
            resumeMode_ff <= mode_ff;
            mode_ff       <= MODE_OSC_OFF_HOLD;
          end else if (sysCtrl2_ff[`SC2_LIGHT_SLEEP]) begin
            resumeMode_ff <= mode_ff;
            if (!dualMode_ff) begin
              mode_ff <= MODE_SINGLE_DOZE;
            end else if (useLowClk_ff) begin
              mode_ff <= MODE_LOW_RATE_DOZE;
            end else begin
              mode_ff <= MODE_DUAL_FAST_DOZE;
            end
          end else if (dualMode_ff) begin
            mode_ff <= useLowClk_ff ? MODE_LOW_RATE_RUN : MODE_DUAL_FAST_RUN;
          end
        end
        MODE_SINGLE_DOZE, MODE_DUAL_FAST_DOZE, MODE_LOW_RATE_DOZE: begin
          if (intRequest) begin
            mode_ff          <= resumeMode_ff;
            serviceInterrupt <= interruptMasterEnable;
          end
        end
        MODE_OSC_OFF_HOLD: begin
          if (wakeEvent) begin
            mode_ff      <= MODE_WARM_UP;
            warmStart_ff <= 1'b1;
            warmArmed_ff <= 1'b0;
          end
        end
        MODE_WARM_UP: begin
          if (!warmStart_ff) begin
            warmArmed_ff <= 1'b1;
          end
          if (warmArmed_ff && warmBit) begin
            mode_ff <= resumeMode_ff;
          end
        end
        default: begin
          mode_ff <= MODE_SINGLE_RUN;
        end
      endcase
    end
  end

  // register bank, one concern per block
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sysCtrl1_ff <= `SC1_RESET;
    end else if (clkEn) begin
      if (wrStrobe && wb_adr_i == `OFS_SYSCTRL1) begin
        sysCtrl1_ff <= wb_dat_i[7:0];
      end else if (mode_ff == MODE_OSC_OFF_HOLD) begin
        sysCtrl1_ff[`SC1_DEEP_HALT] <= 1'b0;
      end
    end
  end

  // reset option loads the oscillator enables
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sysCtrl2_ff <= `SC2_RESET_SINGLE;
    end else if (clkEn) begin
      if (!modeCaptured_ff) begin
        sysCtrl2_ff <= dualClockOption ? `SC2_RESET_DUAL : `SC2_RESET_SINGLE;
      end else if (wrStrobe && wb_adr_i == `OFS_SYSCTRL2) begin
        sysCtrl2_ff <= wb_dat_i[7:0];
      end else if (isDozeMode(mode_ff)) begin
        sysCtrl2_ff[`SC2_LIGHT_SLEEP] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      timeBase_ff <= `TB_RESET;
    end else if (clkEn && wrStrobe && wb_adr_i == `OFS_TIMEBASE) begin
      timeBase_ff <= wb_dat_i[7:0];
    end
  end

  // one-cycle ack, read data held until the next read
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else if (clkEn) begin
      wb_ack_o <= busHit;
      if (busHit && !wb_we_i) begin
        wb_dat_o <= {24'h00_0000, regRead(wb_adr_i, sysCtrl1_ff, sysCtrl2_ff, timeBase_ff,
                                          {dualMode_ff, useLowClk_ff, 3'h0, 3'(mode_ff)})};
      end
    end
  end

  // registered outputs
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      mainClkTick       <= 1'b0;
      machineState      <= 2'h0;
      cpuRun            <= 1'b0;
      watchdogRun       <= 1'b0;
      periphRun         <= 1'b0;
      highOscOn         <= 1'b1;
      lowOscOn          <= 1'b0;
      lowOscPinsAsPorts <= 1'b1;
      outputsHiZ        <= 1'b0;
      dividerPulseOut   <= 1'b0;
      periphClk         <= '0;
      resetOutRelease   <= 1'b0;
    end else if (clkEn) begin
      mainClkTick  <= mainTick;
      machineState <= state_ff;
      cpuRun       <= isRunMode(mode_ff);
      watchdogRun  <= isRunMode(mode_ff);
      periphRun    <= mode_ff != MODE_OSC_OFF_HOLD && mode_ff != MODE_WARM_UP;
      highOscOn    <= mode_ff != MODE_OSC_OFF_HOLD && mode_ff != MODE_LOW_RATE_RUN &&
                      mode_ff != MODE_LOW_RATE_DOZE &&
                      !(dualMode_ff && sysCtrl2_ff[`SC2_SYSCLK_SEL] && useLowClk_ff &&
                        !sysCtrl2_ff[`SC2_HF_ENABLE]);
      lowOscOn     <= dualMode_ff ? (mode_ff != MODE_OSC_OFF_HOLD) :
                      sysCtrl2_ff[`SC2_LF_ENABLE];
      lowOscPinsAsPorts <= !dualMode_ff && !sysCtrl2_ff[`SC2_LF_ENABLE];
      outputsHiZ   <= (mode_ff == MODE_OSC_OFF_HOLD) && sysCtrl1_ff[`SC1_OUT_HIZ];
      dividerPulseOut       <= divider_ff[8] && isFastMode(mode_ff) || divider_ff[8];
      periphClk.timeBaseClk <= stageRise[14];
      periphClk.watchdogClk <= stageRise[15];
      periphClk.timerClk    <= {divider_ff[19], divider_ff[13], divider_ff[11], divider_ff[6]};
      periphClk.serialClk   <= {divider_ff[7], divider_ff[2]};
      if (divider_ff[`RESET_OUT_STAGE]) begin
        resetOutRelease <= 1'b1;
      end
    end
  end

endmodule : system_clock_standby_controller

`default_nettype wire

// >>> clock_standby_sva.sv
`timescale 1ns/1ps
`default_nettype none
module clock_standby_sva (
  input wire logic       clk_sys,
  input wire logic       reset,
  input wire logic       clkEn,
  input wire logic       wb_cyc_i,
  input wire logic       wb_stb_i,
  input wire logic       wb_ack_o,
  input wire logic [1:0] machineState,
  input wire logic       cpuRun,
  input wire logic       watchdogRun,
  input wire logic       periphRun,
  input wire logic       serviceInterrupt,
  input wire logic       interruptMasterEnable,
  input wire logic       highOscOn,
  input wire logic       lowOscOn,
  input wire logic       lowOscPinsAsPorts,
  input wire logic       outputsHiZ
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  sequence s_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o && clkEn;
  endsequence
  sequence s_oscRestart;
    !highOscOn && !lowOscOn ##1 (highOscOn || lowOscOn);
  endsequence
  property p_ackAnswer; s_take |=> wb_ack_o; endproperty
  a_ackAnswer: assert property (p_ackAnswer) else $error("bus request not answered");
  property p_ackPulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ackPulse: assert property (p_ackPulse) else $error("ack longer than one cycle");
  property p_stateStep;
    $changed(machineState) |-> machineState == $past(machineState) + 2'h1;
  endproperty
  a_stateStep: assert property (p_stateStep) else $error("state skipped");
  property p_pinsPorts; lowOscPinsAsPorts |-> !lowOscOn; endproperty
  a_pinsPorts: assert property (p_pinsPorts) else $error("low osc on in single mode");
  property p_runNoHf; cpuRun && !highOscOn |-> lowOscOn && !lowOscPinsAsPorts; endproperty
  a_runNoHf: assert property (p_runNoHf) else $error("cpu runs with no clock");
  property p_dozeWd; periphRun && !cpuRun |-> !watchdogRun; endproperty
  a_dozeWd: assert property (p_dozeWd) else $error("watchdog runs in doze");
  property p_haltAll; !highOscOn && !lowOscOn |-> !cpuRun && !periphRun; endproperty
  a_haltAll: assert property (p_haltAll) else $error("activity with osc off");
  property p_hiZ; outputsHiZ |-> !cpuRun; endproperty
  a_hiZ: assert property (p_hiZ) else $error("hi-z while running");
  property p_svcRun;
    serviceInterrupt |-> $past(interruptMasterEnable) ##[0:4] cpuRun;
  endproperty
  a_svcRun: assert property (p_svcRun) else $error("bad interrupt service");
  property p_restart; s_oscRestart |-> !cpuRun [*8]; endproperty
  a_restart: assert property (p_restart) else $error("cpu ran during warm-up");
endmodule : clock_standby_sva
bind system_clock_standby_controller clock_standby_sva chk (.clk_sys, .reset, .clkEn,
  .wb_cyc_i, .wb_stb_i, .wb_ack_o, .machineState, .cpuRun, .watchdogRun, .periphRun,
  .serviceInterrupt, .interruptMasterEnable, .highOscOn, .lowOscOn, .lowOscPinsAsPorts,
  .outputsHiZ);
`default_nettype wire

// >>> system_clock_standby_controller_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "clock_standby_consts.svh"
module system_clock_standby_controller_tb_top;
  import clock_standby_pkg::*;
  logic        clk_sys, reset, lowFreqTick, dualClockOption, wakePin, intRequest;
  logic        interruptMasterEnable, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, mainClkTick;
  logic        cpuRun, watchdogRun, periphRun, serviceInterrupt, highOscOn, lowOscOn;
  logic        lowOscPinsAsPorts, outputsHiZ, resetOutRelease;
  logic [1:0]  machineState;
  logic [2:0]  lfCnt;
  logic [3:0]  wb_adr_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  int          n_mismatch, num_checks;
  system_clock_standby_controller uut (.clk_sys, .reset, .clkEn(1'b1), .highFreqTick(1'b1),
    .lowFreqTick, .dualClockOption, .wakePin, .intRequest, .interruptMasterEnable,
    .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i(4'h1), .wb_dat_i, .wb_dat_o,
    .wb_ack_o, .mainClkTick, .machineState, .cpuRun, .watchdogRun, .periphRun,
    .serviceInterrupt, .highOscOn, .lowOscOn, .lowOscPinsAsPorts, .outputsHiZ,
    .dividerPulseOut(), .periphClk(), .resetOutRelease);
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  // slow oscillator period is eight system cycles
  always @(posedge clk_sys) begin
    if (reset) begin
      lfCnt       <= 3'h0;
      lowFreqTick <= 1'b0;
    end else begin
      lfCnt       <= lfCnt + 3'h1;
      lowFreqTick <= (lfCnt == 3'h7);
    end
  end
  task results;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : results
  task chk8(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk8
  task wbXfer(input logic we, input logic [3:0] a, input logic [7:0] d, output logic [7:0] q);
    int n;
    @(posedge clk_sys);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= {24'h00_0000, d};
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    q = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
    if (wb_ack_o !== 1'b1) begin
      n_mismatch++;
      results();
    end
  endtask : wbXfer
  task rd(input logic [3:0] a, input logic [7:0] exp);
    logic [7:0] q;
    wbXfer(1'b0, a, 8'h00, q);
    chk8(q, exp);
  endtask : rd
  task wr(input logic [3:0] a, input logic [7:0] d);
    logic [7:0] q;
    wbXfer(1'b1, a, d, q);
  endtask : wr
  task waitCpu(input logic v, output int n);
    n = 0;
    while (cpuRun !== v && n < 5000) begin
      @(posedge clk_sys);
      n++;
    end
    if (cpuRun !== v) begin
      n_mismatch++;
      results();
    end
  endtask : waitCpu
  task doReset(input logic dual);
    dualClockOption <= dual;
    reset <= 1'b1;
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask : doReset
  task t_single;
    logic [1:0] st;
    doReset(1'b0);
    rd(`OFS_STATUS, 8'h00);
    rd(`OFS_SYSCTRL2, `SC2_RESET_SINGLE);
    chk8({6'h00, lowOscPinsAsPorts, lowOscOn}, 8'h02);
    chk8({7'h00, mainClkTick}, 8'h01);
    st = machineState;
    @(posedge clk_sys);
    chk8({6'h00, machineState}, {6'h00, st + 2'h1});
    rd(4'h2, 8'h00);
    $display("test single done");
  endtask : t_single
  task t_doze;
    int n;
    wr(`OFS_SYSCTRL2, 8'h90);
    repeat (4) @(posedge clk_sys);
    rd(`OFS_STATUS, 8'h01);
    chk8({5'h00, cpuRun, watchdogRun, periphRun}, 8'h01);
    interruptMasterEnable <= 1'b1;
    intRequest <= 1'b1;
    n = 0;
    while (serviceInterrupt !== 1'b1 && n < 1000) begin
      @(posedge clk_sys);
      n++;
    end
    chk8({7'h00, serviceInterrupt}, 8'h01);
    intRequest <= 1'b0;
    repeat (4) @(posedge clk_sys);
    rd(`OFS_STATUS, 8'h00);
    rd(`OFS_SYSCTRL2, 8'h80);
    wr(`OFS_SYSCTRL2, 8'hC0);
    repeat (2) @(posedge clk_sys);
    chk8({6'h00, lowOscPinsAsPorts, lowOscOn}, 8'h01);
    $display("test doze done");
  endtask : t_doze
  task t_dual;
    doReset(1'b1);
    rd(`OFS_STATUS, 8'h83);
    rd(`OFS_SYSCTRL2, `SC2_RESET_DUAL);
    chk8({6'h00, lowOscPinsAsPorts, lowOscOn}, 8'h01);
    chk8({7'h00, resetOutRelease}, 8'h00);
    wr(`OFS_TIMEBASE, 8'h10);
    rd(`OFS_TIMEBASE, 8'h10);
    wr(`OFS_SYSCTRL2, 8'hE0);
    repeat (8) @(posedge clk_sys);
    rd(`OFS_STATUS, 8'hC5);
    chk8({6'h00, highOscOn, cpuRun}, 8'h01);
    $display("test dual done");
  endtask : t_dual
  task t_hold;
    int n;
    // deep halt, outputs high-impedance, slow-clock warm-up
    wr(`OFS_SYSCTRL1, 8'hC1);
    waitCpu(1'b0, n);
    repeat (2) @(posedge clk_sys);
    chk8({5'h00, highOscOn, periphRun, outputsHiZ}, 8'h01);
    wakePin <= 1'b1;
    waitCpu(1'b1, n);
    chk8({7'h00, n > 8}, 8'h01);
    wakePin <= 1'b0;
    rd(`OFS_STATUS, 8'hC5);
    rd(`OFS_SYSCTRL1, 8'h41);
    chk8({7'h00, outputsHiZ}, 8'h00);
    n = 0;
    while (resetOutRelease !== 1'b1 && n < 2000) begin
      @(posedge clk_sys);
      n++;
    end
    chk8({7'h00, resetOutRelease}, 8'h01);
    $display("test hold done");
  endtask : t_hold
  initial begin
    reset = 1'b1;
    dualClockOption = 1'b0;
    wakePin = 1'b0;
    intRequest = 1'b0;
    interruptMasterEnable = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 4'h0;
    wb_dat_i = 32'h0000_0000;
    n_mismatch = 0;
    num_checks = 0;
    t_single();
    t_doze();
    t_dual();
    t_hold();
    results();
  end
endmodule : system_clock_standby_controller_tb_top
`default_nettype wire
